// File: rtl/pdi2c_pkg.sv
// Constants and types shared by the two-wire output register block
package pdi2c_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] REG_FIRST = 4'h0;  // Pointer after a fresh read
    localparam logic [3:0] REG_LAST  = 4'hB;  // Pointer saturates here
    localparam logic [3:0] CH1_OFS   = 4'h6;  // channel1_ramp_level
    localparam logic [3:0] CH4_OFS   = 4'h9;  // channel4_ramp_level
    localparam int         NUM_CH    = 4;     // Output channels

    // ==========================================================
    // Field layout of a channel byte
    localparam int         RAMP_MSB  = 7;     // ramp_duration_code
    localparam int         RAMP_LSB  = 5;
    localparam int         LEVEL_MSB = 4;     // Peak-to-peak level code
    localparam int         LEVEL_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00; // Channel byte after reset

    // ==========================================================
    // Serial framing
    localparam logic [3:0] BITS_BYTE = 4'h8;  // Data bits before the ack
    localparam logic [4:0] DEV_ADDR_HI_DEF = 5'h14; // Upper address, arbitrary
    localparam logic [3:0] SYNC_RESET = 4'hF; // Pins idle high

    // Channel byte split into its two codes
    typedef struct packed {
        logic [2:0] ramp_duration_code; // Ramp time selection
        logic [4:0] level_code;         // Peak-to-peak level
    } pdi2c_cfg_s;

    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } pdi2c_state_e;
endpackage

// File: rtl/pdi2c_sync.sv
// Two-flop synchroniser for the bus and strap pins
`timescale 1ns/100ps
module pdi2c_sync (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    // Asynchronous pins and their synchronised copy
    input  wire logic [3:0] i_async,
    output logic      [3:0] o_sync
);
    logic [3:0] meta_reg;  // First stage, read only by the second
    logic [3:0] sync_reg;  // Second stage
    logic [3:0] meta_next;
    logic [3:0] sync_next;

    // ==========================================================
    // Next values
    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    // Registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_reg <= pdi2c_pkg::SYNC_RESET;
            sync_reg <= pdi2c_pkg::SYNC_RESET;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule // pdi2c_sync

// File: rtl/pdi2c_regfile.sv
// Channel configuration registers behind the serial pointer
`timescale 1ns/100ps
module pdi2c_regfile (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset_n,
    // Write port
    input  wire logic                   i_wr_en,
    input  wire logic [3:0]             i_wr_addr,
    input  wire logic [7:0]             i_wr_data,
    // Read port
    input  wire logic [3:0]             i_rd_addr,
    output logic      [7:0]             o_rd_data,
    // Channel settings
    output pdi2c_pkg::pdi2c_cfg_s [3:0] o_chan_cfg
);
    pdi2c_pkg::pdi2c_cfg_s [3:0] cfg_reg;  // One byte per channel
    pdi2c_pkg::pdi2c_cfg_s [3:0] cfg_next;

    // True when the offset names a channel register
    function automatic logic is_chan(input logic [3:0] a);
        return (a >= pdi2c_pkg::CH1_OFS) && (a <= pdi2c_pkg::CH4_OFS);
    endfunction

    // Channel index of an offset
    function automatic logic [1:0] chan_idx(input logic [3:0] a);
        logic [3:0] d;
        d = a - pdi2c_pkg::CH1_OFS;
        return d[1:0];
    endfunction

    // ==========================================================
    // Write decode, bits 7..5 ramp code and 4..0 level code
    always_comb begin
        cfg_next = cfg_reg;
        if (i_wr_en && is_chan(i_wr_addr)) begin
            cfg_next[chan_idx(i_wr_addr)] = i_wr_data;
        end
    end

    // Registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cfg_reg <= {pdi2c_pkg::NUM_CH{pdi2c_pkg::CFG_RESET}};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Read mux, unimplemented offsets read zero
    always_comb begin
        o_rd_data = 8'h00;
        if (is_chan(i_rd_addr)) begin
            o_rd_data = cfg_reg[chan_idx(i_rd_addr)];
        end
    end

    assign o_chan_cfg = cfg_reg;

    // Channel write lands in the addressed byte
    chan_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_wr_en && is_chan(i_wr_addr)
        |=> o_chan_cfg[chan_idx($past(i_wr_addr))] == $past(i_wr_data))
        else $error("channel byte not written");
endmodule // pdi2c_regfile

// File: rtl/pdi2c_top.sv
// Two-wire slave port with pointer and channel output registers
`timescale 1ns/100ps
module pdi2c_top #(
    parameter logic [4:0] DEV_ADDR_HI = pdi2c_pkg::DEV_ADDR_HI_DEF
) (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset_n,
    // Serial bus pins
    input  wire logic                   i_scl,
    input  wire logic                   i_sda_i,
    output logic                        o_sda_o,
    output logic                        o_sda_oe,
    // Address straps
    input  wire logic                   i_addr_strap_low,
    input  wire logic                   i_addr_strap_high,
    // Channel settings
    output pdi2c_pkg::pdi2c_cfg_s [3:0] o_chan_cfg
);
    // ==========================================================
    // Pin synchronisation and edge detection
    logic [3:0] pins_sync;  // {strap_high, strap_low, scl, sda}
    logic       scl_s;      // Synchronised clock
    logic       sda_s;      // Synchronised data
    logic       scl_d_reg;  // Clock one cycle back
    logic       sda_d_reg;  // Data one cycle back
    logic       scl_rise;   // Clock rising edge
    logic       scl_fall;   // Clock falling edge
    logic       start_det;  // Start condition
    logic       stop_det;   // Stop condition

    pdi2c_sync u_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_addr_strap_high, i_addr_strap_low, i_scl, i_sda_i}),
        .o_sync    (pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // Edges seen on the sampled link clock
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ==========================================================
    // Strap capture: follows the pins until the first start, then frozen.
    // The first edge after release would only see the synchroniser reset value.
    logic [1:0] strap_reg;      // Low slave address bits
    logic [1:0] strap_next;
    logic       strap_done_reg; // Capture has happened
    logic       strap_done_next;

    // Next values
    always_comb begin
        strap_next      = strap_reg;
        strap_done_next = strap_done_reg | start_det;
        if (!strap_done_reg) begin
            strap_next = pins_sync[3:2];
        end
    end

    // Registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            strap_reg      <= 2'b00;
            strap_done_reg <= 1'b0;
        end else begin
            strap_reg      <= strap_next;
            strap_done_reg <= strap_done_next;
        end
    end

    // ==========================================================
    // Serial engine state
    pdi2c_pkg::pdi2c_state_e state_reg, state_next; // Frame position
    logic [3:0] cnt_reg, cnt_next;       // Bits of current byte
    logic [7:0] shift_reg, shift_next;   // Receive shifter
    logic [7:0] tx_reg, tx_next;         // Transmit shifter
    logic [3:0] ptr_reg, ptr_next;       // Register pointer
    logic       oe_reg, oe_next;         // Data line pulled low
    logic       rw_reg, rw_next;         // Read direction latched
    logic       nack_reg, nack_next;     // Master answered not-ack
    logic       sess_reg, sess_next;     // Between start and stop
    logic       rep_reg, rep_next;       // Last start was repeated
    logic       hold_reg, hold_next;     // Start seen in this high pulse
    logic       wr_en;                   // Commit received byte
    logic [7:0] rd_data;                 // Byte at the pointer

    // Pointer step that stops at the last register
    function automatic logic [3:0] sat_inc(input logic [3:0] p);
        return (p >= pdi2c_pkg::REG_LAST) ? pdi2c_pkg::REG_LAST : p + 4'h1;
    endfunction

    pdi2c_regfile u_regs (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_wr_en    (wr_en),
        .i_wr_addr  (ptr_reg),
        .i_wr_data  (shift_reg),
        .i_rd_addr  (ptr_reg),
        .o_rd_data  (rd_data),
        .o_chan_cfg (o_chan_cfg)
    );

    // Next state of the serial engine
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        ptr_next   = ptr_reg;
        oe_next    = oe_reg;
        rw_next    = rw_reg;
        nack_next  = nack_reg;
        sess_next  = sess_reg;
        rep_next   = rep_reg;
        hold_next  = hold_reg & ~scl_fall;
        wr_en      = 1'b0;
        if (stop_det && !hold_reg) begin
            // Stop ends the frame wherever it falls, except in the same clock-high pulse as a start
            state_next = pdi2c_pkg::ST_IDLE;
            sess_next  = 1'b0;
            oe_next    = 1'b0;
        end else if (start_det) begin
            // Start or repeated start opens an address byte
            state_next = pdi2c_pkg::ST_ADDR;
            cnt_next   = 4'h0;
            rep_next   = sess_reg;
            sess_next  = 1'b1;
            hold_next  = 1'b1;
            oe_next    = 1'b0;
        end else begin
            unique case (state_reg)
                pdi2c_pkg::ST_IDLE: begin
                    // Released, waiting for a start
                    oe_next = 1'b0;
                end
                pdi2c_pkg::ST_ADDR, pdi2c_pkg::ST_PTR, pdi2c_pkg::ST_WDATA: begin
                    // Sample one bit per rising clock
                    if (scl_rise && cnt_reg < pdi2c_pkg::BITS_BYTE) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == pdi2c_pkg::BITS_BYTE) begin
                        cnt_next = 4'h0;
                        oe_next  = 1'b1;
                        if (state_reg == pdi2c_pkg::ST_ADDR) begin
                            if (shift_reg[7:1] == {DEV_ADDR_HI, strap_reg}) begin
                                state_next = pdi2c_pkg::ST_ADDR_ACK;
                                rw_next    = shift_reg[0];
                                if (shift_reg[0] && !rep_reg) begin
                                    ptr_next = pdi2c_pkg::REG_FIRST;
                                end
                            end else begin
                                // Other slave addressed
                                state_next = pdi2c_pkg::ST_IDLE;
                                oe_next    = 1'b0;
                            end
                        end else if (state_reg == pdi2c_pkg::ST_PTR) begin
                            // Pointer byte, clamped to the map
                            state_next = pdi2c_pkg::ST_PTR_ACK;
                            ptr_next   = (shift_reg > {4'h0, pdi2c_pkg::REG_LAST}) ?
                                         pdi2c_pkg::REG_LAST : shift_reg[3:0];
                        end else begin
                            // Data byte stored at the pointer
                            state_next = pdi2c_pkg::ST_WDATA_ACK;
                            wr_en      = 1'b1;
                            ptr_next   = sat_inc(ptr_reg);
                        end
                    end
                end
                pdi2c_pkg::ST_ADDR_ACK: begin
                    // End of ack pulse: send first byte or take pointer
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (rw_reg) begin
                            state_next = pdi2c_pkg::ST_RDATA;
                            tx_next    = {rd_data[6:0], 1'b0};
                            oe_next    = ~rd_data[7];
                        end else begin
                            state_next = pdi2c_pkg::ST_PTR;
                            oe_next    = 1'b0;
                        end
                    end
                end
                pdi2c_pkg::ST_PTR_ACK, pdi2c_pkg::ST_WDATA_ACK: begin
                    // Release after the ninth pulse, more data may follow
                    if (scl_fall) begin
                        state_next = pdi2c_pkg::ST_WDATA;
                        cnt_next   = 4'h0;
                        oe_next    = 1'b0;
                    end
                end
                pdi2c_pkg::ST_RDATA: begin
                    // Shift out on falling clock, counted on rising
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == pdi2c_pkg::BITS_BYTE) begin
                            state_next = pdi2c_pkg::ST_RACK;
                            oe_next    = 1'b0;
                            ptr_next   = sat_inc(ptr_reg);
                        end else begin
                            oe_next = ~tx_reg[7];
                            tx_next = {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                pdi2c_pkg::ST_RACK: begin
                    // Master answers the byte
                    if (scl_rise) begin
                        nack_next = sda_s;
                    end else if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (nack_reg) begin
                            state_next = pdi2c_pkg::ST_IDLE;
                            oe_next    = 1'b0;
                        end else begin
                            state_next = pdi2c_pkg::ST_RDATA;
                            tx_next    = {rd_data[6:0], 1'b0};
                            oe_next    = ~rd_data[7];
                        end
                    end
                end
                default: begin
                    state_next = pdi2c_pkg::ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    // Registers of the serial engine
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg <= pdi2c_pkg::ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg    <= 8'h00;
            ptr_reg   <= pdi2c_pkg::REG_FIRST;
            oe_reg    <= 1'b0;
            rw_reg    <= 1'b0;
            nack_reg  <= 1'b0;
            sess_reg  <= 1'b0;
            rep_reg   <= 1'b0;
            hold_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            tx_reg    <= tx_next;
            ptr_reg   <= ptr_next;
            oe_reg    <= oe_next;
            rw_reg    <= rw_next;
            nack_reg  <= nack_next;
            sess_reg  <= sess_next;
            rep_reg   <= rep_next;
            hold_reg  <= hold_next;
        end
    end

    // Open-drain: the data value is always low, only the enable moves
    always_ff @(posedge i_mclk) begin
        o_sda_o <= 1'b0;
    end

    assign o_sda_oe = oe_reg;

    // ==========================================================
    // Checks
    start_opens_addr_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        start_det && !(stop_det && !hold_reg)
        |=> state_reg == pdi2c_pkg::ST_ADDR && cnt_reg == 4'h0 && !oe_reg)
        else $error("start did not open an address byte");

    stop_release_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        stop_det && !hold_reg |=> state_reg == pdi2c_pkg::ST_IDLE && !o_sda_oe && !sess_reg)
        else $error("stop did not end the frame");

    ptr_bound_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        ptr_reg <= pdi2c_pkg::REG_LAST)
        else $error("pointer beyond last register");

    fresh_read_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_reg == pdi2c_pkg::ST_ADDR && scl_fall && cnt_reg == 4'h8 && !rep_reg
        && shift_reg == {DEV_ADDR_HI, strap_reg, 1'b1} && !start_det && !stop_det
        |=> ptr_reg == pdi2c_pkg::REG_FIRST && o_sda_oe)
        else $error("fresh read did not reset pointer");

    ack_hold_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (state_reg == pdi2c_pkg::ST_PTR_ACK || state_reg == pdi2c_pkg::ST_WDATA_ACK)
        && scl_s |-> o_sda_oe)
        else $error("ack released during ninth pulse");

    drive_on_fall_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(o_sda_oe) |-> $past(scl_fall))
        else $error("data line pulled outside a clock fall");

    drive_states_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_sda_oe |-> state_reg inside {pdi2c_pkg::ST_ADDR_ACK, pdi2c_pkg::ST_PTR_ACK,
                                       pdi2c_pkg::ST_WDATA_ACK, pdi2c_pkg::ST_RDATA})
        else $error("data line pulled in a listening state");

    write_step_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        wr_en && ptr_reg < pdi2c_pkg::REG_LAST |=> ptr_reg == $past(ptr_reg) + 4'h1)
        else $error("pointer did not advance after write");

    nack_idle_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_reg == pdi2c_pkg::ST_RACK && nack_reg && scl_fall && !start_det && !stop_det
        |=> state_reg == pdi2c_pkg::ST_IDLE ##1 !o_sda_oe)
        else $error("not-ack did not release the line");
endmodule // pdi2c_top

// File: test/pdi2c_master.sv
// Behavioural two-wire bus master that clocks the slave port
`timescale 1ns/100ps
module pdi2c_master (
    // Clock and bus line
    input  wire logic i_mclk,
    input  wire logic i_sda,
    // Master drive
    output logic      o_scl,
    output logic      o_sda_oe
);
    // ==========================================================
    // Bus idles high
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // Waits n falling edges of the system clock
    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    // One 800 ns clock cycle; data changes mid-low, sampled before the fall
    task automatic bit_x(input logic b, output logic r);
        wt(2);
        o_sda_oe = ~b;
        wt(2);
        o_scl = 1'b1;
        wt(4);
        r = i_sda;
        o_scl = 1'b0;
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start();
        wt(2);
        o_sda_oe = 1'b0;
        wt(2);
        o_scl = 1'b1;
        wt(2);
        o_sda_oe = 1'b1;
        wt(2);
        o_scl = 1'b0;
    endtask

    // Stop: data rises while clock high, bus left idle
    task automatic stop();
        wt(2);
        o_sda_oe = 1'b1;
        wt(2);
        o_scl = 1'b1;
        wt(2);
        o_sda_oe = 1'b0;
    endtask

    // Eight bits MSB first, then the acknowledge pulse
    task automatic xbyte(input logic [7:0] d, input logic nak,
                         output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(nak, a);
    endtask
endmodule // pdi2c_master

// File: test/tb.sv
// Self-checking bench for the two-wire output register block
`timescale 1ns/100ps
module tb;
    // ==========================================================
    // Signals
    logic                        mclk, reset_n;      // Clock and reset
    logic                        scl, m_oe, sda;     // Bus lines
    logic                        sda_o, sda_oe;      // Slave drive
    pdi2c_pkg::pdi2c_cfg_s [3:0] cfg;                // Channel bytes
    int                          error_cnt, samples_checked;
    logic [7:0]                  q, v;               // Byte scratch
    logic                        a;                  // Ack bit seen
    localparam logic [6:0] SLV = {pdi2c_pkg::DEV_ADDR_HI_DEF, 2'b10};

    // Pull-up wire: low when either party pulls it
    assign sda = ~((sda_oe & ~sda_o) | m_oe);

    pdi2c_top uut (.i_mclk(mclk), .i_reset_n(reset_n), .i_scl(scl), .i_sda_i(sda),
                   .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_strap_low(1'b0),
                   .i_addr_strap_high(1'b1), .o_chan_cfg(cfg));
    pdi2c_master m (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

    always #50 mclk = ~mclk;

    // ==========================================================
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Byte to the slave, expecting its ack
    task automatic send(input logic [7:0] d);
        m.xbyte(d, 1'b1, q, a);
        check(a, 1'b0);
    endtask

    // Write frame: pointer then n bytes from the top of d
    task automatic wr(input logic [3:0] p, input logic [31:0] d, input int n);
        m.start();
        send({SLV, 1'b0});
        send({4'h0, p});
        for (int i = 0; i < n; i++) send(d[31-8*i -: 8]);
        m.stop();
    endtask

    // Read n bytes, optionally preset by repeated start
    task automatic rd(input logic pre, input logic [3:0] p, input int n,
                      input logic [63:0] e);
        logic [63:0] got;
        got = '0;
        if (pre) begin
            m.start();
            send({SLV, 1'b0});
            send({4'h0, p});
        end
        m.start();
        send({SLV, 1'b1});
        for (int i = 0; i < n; i++) begin
            m.xbyte(8'hFF, 1'(i == n - 1), q, a);
            got = {got[55:0], q};
        end
        m.stop();
        check(got, e);
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        check(cfg, 32'h0000_0000);
        // Burst over all four channels
        wr(4'h6, 32'hA1B2_C3D4, 4);
        check(cfg, 32'hD4C3_B2A1);
        // Fresh read starts at zero
        rd(1'b0, 4'h0, 8, 64'h0000_0000_0000_A1B2);
        // Preset read runs into the top register
        rd(1'b1, 4'h8, 5, 64'h0000_00C3_D400_0000);
        // Read after a stop restarts at zero, not at the saturated pointer
        rd(1'b0, 4'h0, 7, 64'h0000_0000_0000_00A1);
        // Write past the last channel register
        wr(4'h9, 32'h1122_3300, 3);
        check(cfg, 32'h11C3_B2A1);
        // Every ramp code, level extremes included
        for (int k = 0; k < 8; k++) begin
            v = {k[2:0], (k == 7) ? 5'h1F : 5'(k * 4)};
            wr(4'h7, {v, 24'h0}, 1);
            check(cfg[1], v);
        end
        // Strap bits swapped: not our address
        m.start();
        m.xbyte({pdi2c_pkg::DEV_ADDR_HI_DEF, 2'b01, 1'b0}, 1'b1, q, a);
        check(a, 1'b1);
        m.stop();
        // Stop in mid-byte discards the partial byte
        m.start();
        send({SLV, 1'b0});
        send(8'h06);
        for (int i = 0; i < 4; i++) m.bit_x(1'b0, a);
        m.stop();
        repeat (20) @(negedge mclk);
        check(cfg[0], 8'hA1);
        check(sda_oe, 1'b0);
        end_sim();
    end

    // Watchdog against a hung bus, about four times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
endmodule // tb
